// *** hdl/eews_pkg.sv ***
package eews_pkg;

    // array geometry
    localparam int MEM_BYTES    = 8192;
    localparam int PAGE_COUNT   = 256;
    localparam int PAGE_BYTES   = 32;
    localparam int ADDR_W       = 13;
    localparam int PAGE_OFS_W   = 5;
    localparam int BYTE_W       = 8;

    // device address word layout
    localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
    localparam int         DEV_TYPE_MSB  = 7;
    localparam int         DEV_TYPE_LSB  = 4;
    localparam int         DEV_SEL_MSB   = 3;
    localparam int         DEV_SEL_LSB   = 1;
    localparam int         DEV_RW_BIT    = 0;

    // bit counter marks: eight data bits, then the ninth (acknowledge) clock
    localparam logic [3:0] BIT_CNT_RST  = 4'h0;
    localparam logic [3:0] BIT_CNT_ACK  = 4'h8;
    localparam logic [3:0] BIT_CNT_LAST = 4'h9;

    // programming time, longest time rounded down
    localparam int CLK_FREQ_MHZ = 100;
    localparam int PROG_TIME_US = 5000;
    localparam int PROG_CYCLES  = (PROG_TIME_US * CLK_FREQ_MHZ);
    localparam int TIMER_W      = 19;
    // sync delay plus commit and return cycles taken off the timer load
    localparam int PROG_OVERHEAD = 4;

    // receive buffer
    localparam int FIFO_DEPTH = 8;

    // reset values
    localparam logic [1:0] SYNC_RST_2 = 2'h0;
    localparam logic [5:0] SYNC_RST_6 = 6'h00;
    localparam logic [1:0] SYNC_IDLE_2 = 2'h3;
    localparam logic       LINE_IDLE   = 1'h1;
    localparam logic       STANDBY_RST = 1'h1;

    // bus-side states
    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_DEV_ADDR,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_DATA,
        ST_READ,
        ST_PROG
    } eews_state_t;

endpackage : eews_pkg

// *** hdl/eews_fifo.sv ***
`timescale 1ns/1ps
module eews_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_sys_rst,
    // filling side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // draining side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            wr_ptr;
        logic [PTR_W-1:0]            rd_ptr;
        logic [CNT_W-1:0]            count;
    } eews_fifo_regs_t;

    eews_fifo_regs_t r;
    eews_fifo_regs_t n;
    logic            push;
    logic            pop;

    // ready and valid from the fill count
    assign o_in_ready  = (r.count != CNT_W'(DEPTH));
    assign o_out_valid = (r.count != '0);
    assign o_out_data  = r.mem[r.rd_ptr];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    // pointer wrap helper
    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
    endfunction : ptr_inc

    // next state
    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wr_ptr] = i_in_data;
            n.wr_ptr        = ptr_inc(r.wr_ptr);
        end
        if (pop) begin
            n.rd_ptr = ptr_inc(r.rd_ptr);
        end
        if (push && !pop) begin
            n.count = r.count + CNT_W'(1);
        end else if (pop && !push) begin
            n.count = r.count - CNT_W'(1);
        end
    end

    // state register
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule : eews_fifo

// *** hdl/eews_slave.sv ***
`timescale 1ns/1ps
// Summary of operation
// - sample on SCL rise, drive after fall
// - unconnected chip selects read as low; here the strap inputs have no pull-down
// - SDA only pulled low or released
// - write protect high blocks all programming
// - array holds 8192 bytes of eight bits
// - 256 pages of 32, 13-bit address
// - SDA fall with SCL high is START
// - SDA rise with SCL high is STOP
// - STOP after write starts timed programming
// - acknowledge each byte on ninth clock
// - standby after power-up, read, programming
// - device address 1010, straps, then R/W
// - mismatch gets no acknowledge, back to standby
// - last address bit picks read or write
// - byte write: two address bytes, one data
// - bus ignored during programming cycle
// - programming finishes within 5 ms
// - page write up to 31 more bytes
// - only low five address bits increment
// - partial page writes are accepted
// - programming erases addressed bytes automatically
// - no address acknowledge while still programming
module eews_slave #(
    parameter int PROG_CYCLES = eews_pkg::PROG_CYCLES,
    parameter int FIFO_DEPTH  = eews_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                        i_clock,
    input  wire logic                        i_sys_rst,
    // two-wire bus pins
    input  wire logic                        i_scl,
    input  wire logic                        i_sda,
    output logic                             o_sda,
    output logic                             o_sda_oe,
    // strap and protect pins
    input  wire logic                        i_chip_select_strap_2,
    input  wire logic                        i_chip_select_strap_1,
    input  wire logic                        i_chip_select_strap_0,
    input  wire logic                        i_write_protect,
    // status
    output logic                             o_standby,
    output logic                             o_programming,
    // array observation port
    input  wire logic [eews_pkg::ADDR_W-1:0] i_peek_addr,
    output logic [eews_pkg::BYTE_W-1:0]      o_peek_data
);

    localparam int PB = eews_pkg::PAGE_BYTES;
    localparam int BW = eews_pkg::BYTE_W;
    localparam int AW = eews_pkg::ADDR_W;
    localparam int OW = eews_pkg::PAGE_OFS_W;
    localparam int TW = eews_pkg::TIMER_W;

    typedef struct packed {
        logic [1:0]            scl_sync;
        logic [1:0]            sda_sync;
        logic [1:0]            wp_sync;
        logic [5:0]            cs_sync;
        logic                  scl_d;
        logic                  sda_d;
        eews_pkg::eews_state_t state;
        eews_pkg::eews_state_t follow;
        logic [3:0]            bit_cnt;
        logic [BW-1:0]         shift;
        logic [AW-1:0]         addr;
        logic [OW-1:0]         wr_ofs;
        logic                  ack_drive;
        logic                  sda_level;
        logic [PB-1:0][BW-1:0] page_data;
        logic [PB-1:0]         page_vld;
        logic [TW-1:0]         timer;
        logic                  push;
        logic [BW-1:0]         push_data;
        logic                  commit;
        logic [BW-1:0]         peek_data;
        logic                  standby;
        logic                  programming;
    } eews_regs_t;

    eews_regs_t    r;
    eews_regs_t    n;
    logic [BW-1:0] mem_r [0:eews_pkg::MEM_BYTES-1];

    // receive buffer wires
    logic          fifo_in_ready;
    logic          fifo_out_valid;
    logic          fifo_out_ready;
    logic [BW-1:0] fifo_out_data;

    // decoded bus events
    logic          scl_now;
    logic          sda_now;
    logic          scl_rise;
    logic          scl_fall;
    logic          bus_start;
    logic          bus_stop;
    logic [2:0]    straps;
    logic          wp_now;

    // program timer load, shortened by the sync delay and the two closing
    // cycles so that STOP to standby stays inside the programming limit
    localparam logic [TW-1:0] TIMER_LOAD = TW'(PROG_CYCLES - eews_pkg::PROG_OVERHEAD);

    // device address match against the straps
    function automatic logic dev_match(input logic [BW-1:0] word, input logic [2:0] sel);
        dev_match = (word[eews_pkg::DEV_TYPE_MSB:eews_pkg::DEV_TYPE_LSB]
                     == eews_pkg::DEV_TYPE_CODE)
                  && (word[eews_pkg::DEV_SEL_MSB:eews_pkg::DEV_SEL_LSB] == sel);
    endfunction : dev_match

    // edges seen on the synchronised pins, second stage only
    assign scl_now   = r.scl_sync[1];
    assign sda_now   = r.sda_sync[1];
    assign scl_rise  = scl_now & ~r.scl_d;
    assign scl_fall  = ~scl_now & r.scl_d;
    assign bus_start = scl_now & r.scl_d & r.sda_d & ~sda_now;
    assign bus_stop  = scl_now & r.scl_d & ~r.sda_d & sda_now;
    assign straps    = r.cs_sync[5:3];
    assign wp_now    = r.wp_sync[1];

    // page latch drains the buffer except while programming
    assign fifo_out_ready = (r.state != eews_pkg::ST_PROG);

    // received data bytes queue between bit engine and page latch
    eews_fifo #(
        .WIDTH (BW),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clock     (i_clock),
        .i_sys_rst   (i_sys_rst),
        .i_in_valid  (r.push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (r.push_data),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_out_ready),
        .o_out_data  (fifo_out_data)
    );

    // next state of the whole slave
    always_comb begin
        n           = r;
        // two-stage synchronisers on every pin
        n.scl_sync  = {r.scl_sync[0], i_scl};
        n.sda_sync  = {r.sda_sync[0], i_sda};
        n.wp_sync   = {r.wp_sync[0], i_write_protect};
        n.cs_sync   = {r.cs_sync[2:0], i_chip_select_strap_2,
                       i_chip_select_strap_1, i_chip_select_strap_0};
        // last settled levels for edge detection
        n.scl_d     = scl_now;
        n.sda_d     = sda_now;
        // one-cycle pulses drop by default
        n.push      = 1'b0;
        n.commit    = 1'b0;
        n.sda_level = 1'b0;
        // observation read, one cycle late
        n.peek_data = mem_r[i_peek_addr];

        case (r.state)
            // self-timed cycle, bus not looked at
            eews_pkg::ST_PROG: begin
                n.ack_drive = 1'b0;
                if (r.timer == TW'(1)) begin
                    n.commit = 1'b1;
                    n.timer  = '0;
                end else if (r.timer == '0) begin
                    n.state    = eews_pkg::ST_STANDBY;
                    n.page_vld = '0;
                end else begin
                    n.timer = r.timer - TW'(1);
                end
            end

            // bus states
            default: begin
                if (bus_start) begin
                    n.state     = eews_pkg::ST_DEV_ADDR;
                    n.bit_cnt   = eews_pkg::BIT_CNT_RST;
                    n.ack_drive = 1'b0;
                end else if (bus_stop) begin
                    n.ack_drive = 1'b0;
                    n.bit_cnt   = eews_pkg::BIT_CNT_RST;
                    if ((r.state == eews_pkg::ST_DATA) && (|r.page_vld) && !wp_now) begin
                        n.state = eews_pkg::ST_PROG;
                        n.timer = TIMER_LOAD;
                    end else begin
                        n.state    = eews_pkg::ST_STANDBY;
                        n.page_vld = '0;
                    end
                end else if (r.state != eews_pkg::ST_STANDBY) begin
                    // data taken on the rising clock
                    if (scl_rise) begin
                        if (r.bit_cnt < eews_pkg::BIT_CNT_ACK) begin
                            n.shift = {r.shift[BW-2:0], sda_now};
                        end
                        if (r.bit_cnt < eews_pkg::BIT_CNT_LAST) begin
                            n.bit_cnt = r.bit_cnt + 4'h1;
                        end
                    end
                    // line changed only after the falling clock
                    if (scl_fall && (r.bit_cnt == eews_pkg::BIT_CNT_ACK)) begin
                        case (r.state)
                            eews_pkg::ST_DEV_ADDR: begin
                                if (dev_match(r.shift, straps)) begin
                                    n.ack_drive = 1'b1;
                                    n.follow    = r.shift[eews_pkg::DEV_RW_BIT]
                                                ? eews_pkg::ST_READ
                                                : eews_pkg::ST_ADDR_HI;
                                end else begin
                                    n.state = eews_pkg::ST_STANDBY;
                                end
                            end
                            eews_pkg::ST_ADDR_HI: begin
                                n.ack_drive = 1'b1;
                                n.addr      = {r.shift[AW-BW-1:0], r.addr[BW-1:0]};
                                n.follow    = eews_pkg::ST_ADDR_LO;
                            end
                            eews_pkg::ST_ADDR_LO: begin
                                n.ack_drive = 1'b1;
                                n.addr      = {r.addr[AW-1:BW], r.shift};
                                n.wr_ofs    = r.shift[OW-1:0];
                                n.page_vld  = '0;
                                n.follow    = eews_pkg::ST_DATA;
                            end
                            eews_pkg::ST_DATA: begin
                                // a full buffer refuses the byte with no acknowledge
                                if (fifo_in_ready) begin
                                    n.ack_drive = 1'b1;
                                    n.push      = 1'b1;
                                    n.push_data = r.shift;
                                end
                                n.follow = eews_pkg::ST_DATA;
                            end
                            default: begin
                                n.follow = r.state;
                            end
                        endcase
                    end
                    // end of the ninth clock: release and move on
                    if (scl_fall && (r.bit_cnt == eews_pkg::BIT_CNT_LAST)) begin
                        n.ack_drive = 1'b0;
                        n.bit_cnt   = eews_pkg::BIT_CNT_RST;
                        n.state     = r.follow;
                    end
                end
            end
        endcase

        // page latch fill after the clears, so a byte landing in the same
        // cycle as a clear is kept; offset wraps inside the page
        if (fifo_out_valid && fifo_out_ready) begin
            n.page_data[r.wr_ofs] = fifo_out_data;
            n.page_vld[r.wr_ofs]  = 1'b1;
            n.wr_ofs              = r.wr_ofs + OW'(1);
        end

        // status flags follow the next state
        n.standby     = (n.state == eews_pkg::ST_STANDBY);
        n.programming = (n.state == eews_pkg::ST_PROG);
    end

    // state register
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // bus lines start at their idle high level: no false edge
            r          <= '0;
            r.scl_sync <= eews_pkg::SYNC_IDLE_2;
            r.sda_sync <= eews_pkg::SYNC_IDLE_2;
            r.scl_d    <= eews_pkg::LINE_IDLE;
            r.sda_d    <= eews_pkg::LINE_IDLE;
            r.wp_sync  <= eews_pkg::SYNC_RST_2;
            r.cs_sync  <= eews_pkg::SYNC_RST_6;
            r.state    <= eews_pkg::ST_STANDBY;
            r.follow   <= eews_pkg::ST_STANDBY;
            r.standby  <= eews_pkg::STANDBY_RST;
        end else begin
            r <= n;
        end
    end

    // array write at the end of the cycle, whole bytes replaced
    always_ff @(posedge i_clock) begin
        if (r.commit) begin
            for (int i = 0; i < PB; i++) begin
                if (r.page_vld[i]) begin
                    mem_r[{r.addr[AW-1:OW], OW'(i)}] <= r.page_data[i];
                end
            end
        end
    end

    // outputs straight from the register
    assign o_sda         = r.sda_level;
    assign o_sda_oe      = r.ack_drive;
    assign o_standby     = r.standby;
    assign o_programming = r.programming;
    assign o_peek_data   = r.peek_data;

endmodule : eews_slave

// *** tb/eews_slave_assertions.sv ***
`timescale 1ns/1ps
module eews_slave_assertions #(
    parameter int PROG_CYCLES = 20
) (
    // watched pins
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda,
    input wire logic o_sda_oe,
    input wire logic i_write_protect,
    input wire logic o_standby,
    input wire logic o_programming
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);
    int cnt_r;
    // length of the running programming cycle
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) cnt_r <= 0;
        else cnt_r <= o_programming ? cnt_r + 1 : 0;
    end
    // acknowledge raised while scl low, then held for eight clock cycles
    sequence ack_up_s;
        $rose(o_sda_oe) && !i_scl;
    endsequence
    sequence ack_hold_s;
        o_sda_oe [*8];
    endsequence
    chk_open_drain: assert property (o_sda == 1'b0)
        else $error("sda value not low");
    chk_out_edge: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("sda drive changed with scl high");
    chk_ack_hold: assert property (ack_up_s |-> ack_hold_s)
        else $error("acknowledge not held");
    chk_prog_quiet: assert property (o_programming |-> !o_sda_oe)
        else $error("bus driven while programming");
    chk_prog_stby: assert property (o_programming |-> !o_standby)
        else $error("standby while programming");
    chk_prog_stop: assert property ($rose(o_programming) |-> i_scl && i_sda)
        else $error("programming without stop");
    chk_wp_block: assert property ($rose(o_programming) |-> !i_write_protect)
        else $error("programming while protected");
    chk_prog_len: assert property (cnt_r <= PROG_CYCLES)
        else $error("programming too long");
    chk_prog_end: assert property ($fell(o_programming) |-> o_standby)
        else $error("no standby after programming");
    chk_stby_start: assert property ($fell(o_standby) |-> i_scl && !i_sda)
        else $error("standby left without start");
    cover property ($rose(o_programming));
endmodule : eews_slave_assertions

bind eews_slave eews_slave_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_write_protect(i_write_protect),
    .o_standby(o_standby), .o_programming(o_programming)
);

// *** tb/eews_master.sv ***
`timescale 1ns/1ps
module eews_master (
    // bus pins
    output logic      o_scl,
    output logic      o_sda_oe,
    input  wire logic i_sda
);
    // idle bus: clock stands high, data released
    initial begin
        o_scl    = 1'b1;
        o_sda_oe = 1'b0;
    end
    // start or repeated start, scl left low
    task automatic start();
        #31 o_sda_oe = 1'b0;
        #31 o_scl = 1'b1;
        #31 o_sda_oe = 1'b1;
        #62 o_scl = 1'b0;
    endtask : start
    // stop from scl low, then bus free time
    task automatic stop();
        #31 o_sda_oe = 1'b1;
        #31 o_scl = 1'b1;
        #31 o_sda_oe = 1'b0;
        #200;
    endtask : stop
    // eight bits msb first, ack read mid ninth clock
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #31 o_sda_oe = ~b[i];
            #31 o_scl = 1'b1;
            #63 o_scl = 1'b0;
        end
        #31 o_sda_oe = 1'b0;
        #31 o_scl = 1'b1;
        #31 ack = ~i_sda;
        #32 o_scl = 1'b0;
    endtask : send
    // a cut byte: only the first n bits, no ninth clock
    task automatic part(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            #31 o_sda_oe = ~b[i];
            #31 o_scl = 1'b1;
            #63 o_scl = 1'b0;
        end
    endtask : part
endmodule : eews_master

// *** tb/eews_slave_tb.sv ***
`timescale 1ns/1ps
module eews_slave_tb;
    localparam int PROG = 400;
    logic        clock;
    logic        sys_rst;
    logic        wp;
    logic [2:0]  sel;
    logic [12:0] peek_addr;
    logic [12:0] a0;
    logic [7:0]  peek_data;
    logic        sda_out;
    logic        sda_oe;
    logic        m_oe;
    logic        scl;
    logic        standby;
    logic        programming;
    logic        ack;
    logic [7:0]  mem [int];
    int          n_fail;
    int          num_checks;
    // open-drain line with pull-up: device value while enabled
    wire         sda = (sda_oe ? sda_out : 1'b1) & ~m_oe;
    // device under test and bus master
    eews_slave #(.PROG_CYCLES(PROG)) u_eews_slave (
        .i_clock(clock), .i_sys_rst(sys_rst), .i_scl(scl), .i_sda(sda),
        .o_sda(sda_out), .o_sda_oe(sda_oe), .i_chip_select_strap_2(sel[2]),
        .i_chip_select_strap_1(sel[1]), .i_chip_select_strap_0(sel[0]),
        .i_write_protect(wp), .o_standby(standby), .o_programming(programming),
        .i_peek_addr(peek_addr), .o_peek_data(peek_data)
    );
    eews_master u_eews_master (.o_scl(scl), .o_sda_oe(m_oe), .i_sda(sda));
    // clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // compare tasks and verdict
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    function automatic logic [7:0] dev(input logic rw);
        return {eews_pkg::DEV_TYPE_CODE, sel, rw};
    endfunction : dev
    // one command; model updated per data byte with in-page wrap, unless write protect is high
    task automatic xfer(input logic [7:0] d0, input logic [12:0] a, input int n,
                        input logic ok);
        logic [7:0] d;
        u_eews_master.start();
        u_eews_master.send(d0, ack);
        chk_bit(ack, ok);
        if (ok && !d0[0]) begin
            u_eews_master.send({3'h0, a[12:8]}, ack);
            chk_bit(ack, 1'b1);
            u_eews_master.send(a[7:0], ack);
            chk_bit(ack, 1'b1);
            for (int i = 0; i < n; i++) begin
                d = 8'($urandom);
                u_eews_master.send(d, ack);
                chk_bit(ack, 1'b1);
                if (!wp) mem[int'({a[12:5], 5'(a[4:0] + i)})] = d;
            end
        end
        u_eews_master.stop();
    endtask : xfer
    // poll while busy, wait for standby, then compare the array
    task automatic done(input logic prog);
        int k;
        chk_bit(programming, prog);
        if (prog) begin
            u_eews_master.start();
            u_eews_master.send(dev(1'b0), ack);
            chk_bit(ack, 1'b0);
            u_eews_master.stop();
        end
        for (k = 0; k < PROG + 100 && standby !== 1'b1; k++) begin
            @(posedge clock);
            #1;
        end
        if (k == PROG + 100) begin
            n_fail++;
            summarize();
        end
        chk_bit(standby, 1'b1);
        foreach (mem[a]) begin
            @(posedge clock);
            #1 peek_addr = 13'(a);
            @(posedge clock);
            #1 chk_byte(peek_data, mem[a]);
        end
    endtask : done
    // main sequence
    initial begin
        n_fail = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        wp = 1'b0;
        sel = 3'h0;
        peek_addr = 13'h0000;
        a0 = 13'h0000;
        ack = 1'b0;
        void'($urandom(32'h1341));
        repeat (10) @(posedge clock);
        #1 sys_rst = 1'b0;
        chk_bit(standby, 1'b1);
        for (int r = 0; r < 2; r++) begin
            @(posedge clock);
            #1 sel = 3'($urandom);
            a0 = 13'($urandom);
            xfer(dev(1'b0), a0, 1, 1'b1);
            done(1'b1);
            xfer(dev(1'b0), {8'($urandom), 5'h1E}, 34, 1'b1);
            done(1'b1);
            xfer(dev(1'b0), 13'($urandom), 3, 1'b1);
            done(1'b1);
            @(posedge clock);
            #1 wp = 1'b1;
            xfer(dev(1'b0), a0, 1, 1'b1);
            done(1'b0);
            @(posedge clock);
            #1 wp = 1'b0;
            xfer(dev(1'b0), a0, 1, 1'b1);
            done(1'b1);
            xfer({4'h5, sel, 1'b0}, a0, 1, 1'b0);
            done(1'b0);
            xfer({4'hA, ~sel, 1'b0}, a0, 1, 1'b0);
            done(1'b0);
            xfer(dev(1'b1), a0, 0, 1'b1);
            done(1'b0);
            u_eews_master.start();
            u_eews_master.send(dev(1'b0), ack);
            u_eews_master.send(8'hFF, ack);
            u_eews_master.part(8'h00, 3);
            xfer(dev(1'b0), a0 ^ 13'h0001, 2, 1'b1);
            done(1'b1);
        end
        summarize();
    end
endmodule : eews_slave_tb
